// ==== rtl/eetc_trap_ctrl.sv ====
// Purpose : trap flag, monitor trap, virtual interrupt and key rights control
//           around enclave entry, exit and asynchronous exit
// Assumes : one operation per cycle on op/op_valid, an instruction boundary
//           is marked by boundary; op_fault reports a faulting instruction
// Notes   : registers over AHB-Lite, zero wait states, always OKAY
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "eetc_regs.svh"
module eetc_trap_ctrl
    import eetc_pkg::*;
(
    input  wire logic          ref_clk,       // 20 MHz core clock
    input  wire logic          sys_rst,       // async reset, active high
    input  wire logic          hsel,          // AHB slave select
    input  wire logic [31:0]   haddr,         // AHB address
    input  wire logic [1:0]    htrans,        // AHB transfer type
    input  wire logic          hwrite,        // AHB write
    input  wire logic [2:0]    hsize,         // AHB size, word only
    input  wire logic [31:0]   hwdata,        // AHB write data
    input  wire logic          hready,        // AHB ready in
    output logic [31:0]        hrdata,        // AHB read data
    output logic               hreadyout,     // AHB ready out
    output logic               hresp,         // AHB response, always OKAY
    input  wire logic          op_valid,      // operation strobe
    input  wire eetc_op_t      op,            // operation code
    input  wire logic          op_fault,      // operation faulted
    input  wire logic          tcs_opt_in,    // tool opt-in flag of entered structure
    input  wire logic          boundary,      // instruction boundary reached
    input  wire logic          other_vmexit,  // another VM exit occurs
    input  wire logic          flag_pop_instruction_tf,       // trap flag value popped
    input  wire logic [1:0]    io_privilege_level,          // io privilege level
    input  wire logic          v86,           // virtual-8086 flag
    input  wire logic          ssa_vif,       // saved virtual flag image on resume
    output logic               trap_flag,     // live trap flag
    output logic               ss_pending,    // single-step pending
    output logic               dbg_exc,       // single-step debug exception, pulse
    output logic               mtf_exit,      // monitor trap exit taken, pulse
    output logic               gp_fault,      // general protection fault, pulse
    output logic               dbg_grant,     // debug leaf access granted, pulse
    output logic               dbg_refuse,    // debug leaf access refused, pulse
    output logic               tcs_opt_clear  // clear opt-in flag of added page, pulse
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    eetc_state_t state;
    logic        opt_in, tf_entry, tf_mask, mtf_mask, mtf_pend, interrupt_return_arm;
    logic        intr_flag, vif, vip;
    logic [4:0]  ctrl;
    logic [31:0] pkr_live, pkr_save;
    logic [2:0]  ssa_img;
    logic        wr_en, rd_act;
    logic [`EETC_ADDR_W-1:0] dp_addr;
    logic        mtf_ctl, pvi_en, vmx_guest, krse, dbg_attr;
    logic        in_enc, is_aex;

    assign mtf_ctl   = ctrl[`EETC_CTRL_MTF];
    assign pvi_en    = ctrl[`EETC_CTRL_PVI];
    assign vmx_guest = ctrl[`EETC_CTRL_VMX];
    assign krse      = ctrl[`EETC_CTRL_KRSE];
    assign dbg_attr  = ctrl[`EETC_CTRL_DBGATTR];
    assign in_enc    = (state == EETC_S_ENC);
    assign is_aex    = op_valid && (op == EETC_OP_AEX || op == EETC_OP_AEX_SMI);

    initial begin
        if (`EETC_ADDR_W < 5) begin
            $error("address width too small for register map");
        end
    end

    // ------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------
    eetc_ahb_slave u_slave (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .hsel    (hsel),
        .haddr   (haddr),
        .htrans  (htrans),
        .hwrite  (hwrite),
        .hready  (hready),
        .wr_en   (wr_en),
        .rd_act  (rd_act),
        .dp_addr (dp_addr)
    );

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {hreadyout, hresp} <= 2'h2;
        end else begin
            {hreadyout, hresp} <= 2'h2;
        end
    end

    // read data is registered, so it is set up in the address phase
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata <= `EETC_ZERO32;
        end else if (hsel && htrans[1] && hready && !hwrite) begin
            if (haddr[`EETC_ADDR_W-1:0] == `EETC_OFF_CTRL) begin
                hrdata <= {27'h000_0000, ctrl};
            end else if (haddr[`EETC_ADDR_W-1:0] == `EETC_OFF_STATUS) begin
                hrdata <= {23'h00_0000, tf_entry, mtf_mask, tf_mask, vip, vif,
                           intr_flag, trap_flag, opt_in, in_enc};
            end else if (haddr[`EETC_ADDR_W-1:0] == `EETC_OFF_PKR_LIVE) begin
                hrdata <= pkr_live;
            end else if (haddr[`EETC_ADDR_W-1:0] == `EETC_OFF_PKR_SAVE) begin
                hrdata <= pkr_save;
            end else if (haddr[`EETC_ADDR_W-1:0] == `EETC_OFF_SSA) begin
                hrdata <= {29'h0000_0000, ssa_img};
            end else begin
                hrdata <= `EETC_ZERO32;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= 5'h00;
        end else if (wr_en && dp_addr == `EETC_OFF_CTRL) begin
            ctrl <= hwdata[4:0];
        end
    end

    // ------------------------------------------------------------
    // enclave residency and classification
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state    <= EETC_S_IDLE;
            {opt_in, tf_entry, tf_mask, mtf_mask} <= 4'h0;
        end else if (op_valid) begin
            case (op)
                EETC_OP_ENTER, EETC_OP_RESUME: begin
                    if (!in_enc && !op_fault) begin
                        state    <= EETC_S_ENC;
                        opt_in   <= tcs_opt_in;
                        tf_entry <= trap_flag;
                        {tf_mask, mtf_mask} <= {2{!tcs_opt_in}}; // opt-out hides stepping
                    end
                end
                EETC_OP_EXIT, EETC_OP_AEX, EETC_OP_AEX_SMI: begin
                    if (in_enc) begin
                        state    <= EETC_S_IDLE;
                        {tf_mask, mtf_mask} <= 2'h0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // trap flag
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trap_flag <= 1'b0;
        end else if (wr_en && dp_addr == `EETC_OFF_STATUS) begin
            trap_flag <= hwdata[`EETC_ST_TF];
        end else if (op_valid && in_enc && !opt_in &&
                     (op == EETC_OP_EXIT || is_aex)) begin
            trap_flag <= tf_entry;
        end else if (op_valid && op == EETC_OP_FLAG_POP_INSTRUCTION) begin
            trap_flag <= (in_enc && !opt_in) ? 1'b0 : flag_pop_instruction_tf;
        end
    end

    // ------------------------------------------------------------
    // single step and monitor trap pending
    // ------------------------------------------------------------
    logic step_now, mtf_now;
    always_comb begin
        step_now = 1'b0;
        mtf_now  = 1'b0;
        if (op_valid) begin
            case (op)
                EETC_OP_PRIVILEGED_ENCLAVE_INSTRUCTION, EETC_OP_PAGE_ADD, EETC_OP_DBG_RD, EETC_OP_DBG_WR: begin
                    step_now = trap_flag;
                    mtf_now  = vmx_guest && mtf_ctl && !op_fault;
                end
                EETC_OP_REPORT, EETC_OP_KEYREQ: begin
                    step_now = trap_flag && !tf_mask && !op_fault;
                    mtf_now  = vmx_guest && mtf_ctl && (op_fault || !mtf_mask);
                end
                EETC_OP_EXIT: begin
                    step_now = in_enc && !opt_in && tf_entry && !op_fault;
                    mtf_now  = in_enc && !opt_in && tf_entry && vmx_guest && mtf_ctl;
                end
                EETC_OP_AEX: begin
                    mtf_now  = in_enc && !opt_in && vmx_guest && mtf_ctl;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {ss_pending, mtf_pend, dbg_exc, mtf_exit} <= 4'h0;
        end else begin
            dbg_exc  <= boundary && ss_pending;
            mtf_exit <= boundary && mtf_pend && !other_vmexit;
            if (step_now || (interrupt_return_arm && boundary)) begin
                ss_pending <= 1'b1;
            end else if (boundary) begin
                ss_pending <= 1'b0;
            end
            if (mtf_now) begin
                mtf_pend <= 1'b1;
            end else if (boundary || other_vmexit) begin
                mtf_pend <= 1'b0;
            end
        end
    end

    // handler entered by interrupt return with trap flag set steps after one instruction
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            interrupt_return_arm <= 1'b0;
        end else if (op_valid && op == EETC_OP_INTERRUPT_RETURN && ssa_img[`EETC_SSA_TF] == 1'b0 &&
                     trap_flag) begin
            interrupt_return_arm <= 1'b1;
        end else if (boundary) begin
            interrupt_return_arm <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // interrupt flags
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {intr_flag, vif, vip, gp_fault} <= 4'h0;
        end else begin
            gp_fault <= 1'b0;
            if (wr_en && dp_addr == `EETC_OFF_STATUS) begin
                intr_flag <= hwdata[`EETC_ST_IF];
                vif       <= hwdata[`EETC_ST_VIF];
                vip       <= hwdata[`EETC_ST_VIP];
            end else if (op_valid && op == EETC_OP_STI) begin
                if (io_privilege_level == `EETC_IO_PRIVILEGE_LEVEL_MAX) begin
                    intr_flag <= 1'b1;
                end else if (pvi_en && !v86 && vip && !vif) begin
                    gp_fault <= 1'b1;
                end else begin
                    intr_flag <= 1'b1;
                end
            end
            // enter, resume and asynchronous exit leave vif and vip alone
        end
    end

    // ------------------------------------------------------------
    // save state image and key rights
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ssa_img <= 3'h0;
        end else if (is_aex && in_enc) begin
            ssa_img[`EETC_SSA_TF]  <= 1'b0;
            ssa_img[`EETC_SSA_VIF] <= vif;
            ssa_img[`EETC_SSA_VIP] <= vip;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pkr_live <= `EETC_ZERO32;
            pkr_save <= `EETC_ZERO32;
        end else if (is_aex && in_enc && krse) begin
            pkr_save <= pkr_live;
            pkr_live <= `EETC_ZERO32;
        end else if (op_valid && op == EETC_OP_RESUME && !in_enc && krse && !op_fault) begin
            pkr_live <= pkr_save;
        end else if (wr_en && dp_addr == `EETC_OFF_PKR_LIVE) begin
            pkr_live <= hwdata;
        end
    end

    // ------------------------------------------------------------
    // debug access gating and page add
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {dbg_grant, dbg_refuse, tcs_opt_clear} <= 3'h0;
        end else begin
            dbg_grant     <= op_valid && (op == EETC_OP_DBG_RD || op == EETC_OP_DBG_WR)
                             && dbg_attr;
            dbg_refuse    <= op_valid && (op == EETC_OP_DBG_RD || op == EETC_OP_DBG_WR)
                             && !dbg_attr;
            tcs_opt_clear <= op_valid && op == EETC_OP_PAGE_ADD;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_DBG_GATE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        op_valid && (op == EETC_OP_DBG_RD || op == EETC_OP_DBG_WR) |=>
            (dbg_grant == $past(dbg_attr)) && (dbg_refuse != $past(dbg_attr)))
        else $error("debug access gate wrong");
    AST_PAGE_ADD: assert property (@(posedge ref_clk) disable iff (sys_rst)
        op_valid && op == EETC_OP_PAGE_ADD |=> tcs_opt_clear)
        else $error("page add did not clear opt-in");
    AST_CLASSIFY: assert property (@(posedge ref_clk) disable iff (sys_rst)
        op_valid && op == EETC_OP_ENTER && !in_enc && !op_fault |=> opt_in == $past(tcs_opt_in))
        else $error("entry classification wrong");
    AST_HOLD_CLASS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_enc && $past(in_enc) |-> $stable(opt_in))
        else $error("classification changed inside enclave");
    AST_PRIVILEGED_ENCLAVE_INSTRUCTION_STEP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        op_valid && op == EETC_OP_PRIVILEGED_ENCLAVE_INSTRUCTION && trap_flag |=> ss_pending)
        else $error("privileged leaf step not pended");
    AST_MTF_DROP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        boundary && other_vmexit |=> !mtf_exit)
        else $error("monitor exit survived other exit");
    AST_TF_RESTORE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        op_valid && op == EETC_OP_EXIT && in_enc && !opt_in && !(wr_en && dp_addr ==
        `EETC_OFF_STATUS) |=> trap_flag == $past(tf_entry))
        else $error("exit did not restore trap flag");
    AST_SSA_TF: assert property (@(posedge ref_clk) disable iff (sys_rst)
        is_aex && in_enc |=> !ssa_img[`EETC_SSA_TF] && ssa_img[`EETC_SSA_VIF] == $past(vif))
        else $error("save image wrong on asynchronous exit");
    AST_FLAG_POP_INSTRUCTION: assert property (@(posedge ref_clk) disable iff (sys_rst)
        op_valid && op == EETC_OP_FLAG_POP_INSTRUCTION && in_enc && !opt_in && !(wr_en && dp_addr ==
        `EETC_OFF_STATUS) |=> !trap_flag)
        else $error("trap flag set after opt-out entry");
    AST_STI_GP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        op_valid && op == EETC_OP_STI && io_privilege_level != `EETC_IO_PRIVILEGE_LEVEL_MAX && pvi_en && !v86 && vip
        && !vif && !wr_en |=> gp_fault && $stable(intr_flag) && $stable(vif))
        else $error("set-interrupt fault case wrong");
    AST_PKR_CLEAR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        is_aex && in_enc && krse |=> pkr_live == `EETC_ZERO32 && pkr_save == $past(pkr_live))
        else $error("key rights not saved and cleared");
    COV_OPTOUT_EXIT: cover property (@(posedge ref_clk) disable iff (sys_rst)
        op_valid && op == EETC_OP_EXIT && in_enc && !opt_in && tf_entry);
    COV_AEX: cover property (@(posedge ref_clk) disable iff (sys_rst) is_aex && in_enc);
    COV_MTF: cover property (@(posedge ref_clk) disable iff (sys_rst) mtf_exit);
endmodule

// ==== rtl/eetc_regs.svh ====
// Purpose : register map and field constants for the enclave trap control block
// Assumes : 32-bit AHB-Lite words, byte addresses
// Notes   : definitions only
`ifndef EETC_REGS_SVH
`define EETC_REGS_SVH
`define EETC_OFF_CTRL      12'h000
`define EETC_OFF_STATUS    12'h004
`define EETC_OFF_PKR_LIVE  12'h008
`define EETC_OFF_PKR_SAVE  12'h00C
`define EETC_OFF_SSA       12'h010
`define EETC_ADDR_W        12
// control register fields
`define EETC_CTRL_MTF      0
`define EETC_CTRL_PVI      1
`define EETC_CTRL_VMX      2
`define EETC_CTRL_KRSE     3
`define EETC_CTRL_DBGATTR  4
// status register fields
`define EETC_ST_IN_ENC     0
`define EETC_ST_OPTIN      1
`define EETC_ST_TF         2
`define EETC_ST_IF         3
`define EETC_ST_VIF        4
`define EETC_ST_VIP        5
`define EETC_ST_TFMASK     6
`define EETC_ST_MTFMASK    7
`define EETC_ST_TF_ENTRY   8
// saved-state image fields
`define EETC_SSA_TF        0
`define EETC_SSA_VIF       1
`define EETC_SSA_VIP       2
`define EETC_IO_PRIVILEGE_LEVEL_MAX      2'h3
`define EETC_CPL_USER      2'h3
`define EETC_ZERO32        32'h0000_0000
`endif

// ==== rtl/eetc_pkg.sv ====
// Purpose : shared types for the enclave trap control block
// Assumes : nothing
// Notes   : leaf and event encodings
package eetc_pkg;
    typedef enum logic [3:0] {
        EETC_OP_NONE, EETC_OP_PRIVILEGED_ENCLAVE_INSTRUCTION, EETC_OP_PAGE_ADD, EETC_OP_DBG_RD, EETC_OP_DBG_WR,
        EETC_OP_ENTER, EETC_OP_RESUME, EETC_OP_EXIT, EETC_OP_REPORT, EETC_OP_KEYREQ,
        EETC_OP_AEX, EETC_OP_AEX_SMI, EETC_OP_FLAG_POP_INSTRUCTION, EETC_OP_STI, EETC_OP_INTERRUPT_RETURN
    } eetc_op_t;
    typedef enum logic [1:0] { EETC_S_IDLE, EETC_S_ENC } eetc_state_t;
endpackage

// ==== rtl/eetc_ahb_slave.sv ====
// Purpose : AHB-Lite slave front end for the enclave trap control block
// Assumes : single word transfers, zero wait states
// Notes   : write strobe appears in the data phase
`timescale 1ns/100ps
`include "eetc_regs.svh"
module eetc_ahb_slave (
    input  wire logic                     ref_clk,    // clock
    input  wire logic                     sys_rst,    // async reset
    input  wire logic                     hsel,       // slave select
    input  wire logic [31:0]              haddr,      // address
    input  wire logic [1:0]               htrans,     // transfer type
    input  wire logic                     hwrite,     // write
    input  wire logic                     hready,     // bus ready
    output logic                          wr_en,      // data-phase write strobe
    output logic                          rd_act,     // data-phase read active
    output logic [`EETC_ADDR_W-1:0]       dp_addr     // data-phase address
);
    logic addr_ok;
    assign addr_ok = hsel && htrans[1] && hready;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_en   <= 1'b0;
            rd_act  <= 1'b0;
            dp_addr <= '0;
        end else begin
            wr_en  <= addr_ok && hwrite;
            rd_act <= addr_ok && !hwrite;
            if (addr_ok) begin
                dp_addr <= haddr[`EETC_ADDR_W-1:0];
            end
        end
    end
endmodule

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench for the enclave trap control block
// Assumes: zero-wait bus slave; ops and boundaries are taken at the edge with their strobe
// Notes: random words come from an xorshift seeded with 8
`timescale 1ns/100ps
`include "eetc_regs.svh"
module testbench;
    import eetc_pkg::*;
    logic        ref_clk, sys_rst, hsel, hwrite, op_valid, op_fault, tcs_opt_in, v86;
    logic        boundary, other_vmexit, flag_pop_instruction_tf, ssa_vif;
    logic [1:0]  htrans, io_privilege_level, ex;
    logic [7:0]  ov;
    logic [31:0] haddr, hwdata, rd, rnd;
    eetc_op_t    op;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, trap_flag, ss_pending, dbg_exc, mtf_exit;
    wire         gp_fault, dbg_grant, dbg_refuse, tcs_opt_clear;
    int          fail_count, n_compared, cyc;
    eetc_trap_ctrl eetc_trap_ctrl_i (.ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .op_valid,
        .op, .op_fault, .tcs_opt_in, .boundary, .other_vmexit, .flag_pop_instruction_tf, .io_privilege_level, .v86,
        .ssa_vif, .trap_flag, .ss_pending, .dbg_exc, .mtf_exit, .gp_fault, .dbg_grant,
        .dbg_refuse, .tcs_opt_clear);
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // {monitor exit after the boundary, trap flag after the asynchronous exit}
    function automatic logic [1:0] exp_aex(input logic [31:0] r);
        return {!r[0] && !r[1] && !r[5], r[0] ? r[4] : r[3]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            finish_test();
        end
    end
    // launched just after a rising edge; each phase held until ready is sampled high
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d = 32'h0);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0_0000, a};
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        rd = hrdata;
        chk("hresp", 1'h0, hresp);
    endtask
    // pulses last one cycle, so they are caught at the falling edge after the taking edge
    task automatic opx(input eetc_op_t o, input logic v = 1'h1, input logic b = 1'h0);
        op_valid <= v;
        op <= o;
        boundary <= b;
        @(posedge ref_clk);
        op_valid <= 1'h0;
        boundary <= 1'h0;
        @(negedge ref_clk);
        ov = {dbg_exc, mtf_exit, gp_fault, dbg_grant, dbg_refuse, tcs_opt_clear,
              trap_flag, ss_pending};
        @(posedge ref_clk);
    endtask
    initial begin
        sys_rst = 1'h1;
        {hsel, hwrite, op_valid, op_fault, tcs_opt_in, v86, boundary, other_vmexit} = 8'h00;
        {htrans, io_privilege_level, flag_pop_instruction_tf, ssa_vif, haddr, hwdata} = 70'h0;
        op = EETC_OP_NONE;
        rnd = 32'h0000_0008;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'h0;
        @(posedge ref_clk);
        chk("hreadyout", 1'h1, hreadyout);
        bus(1'h1, `EETC_OFF_CTRL);
        opx(EETC_OP_DBG_RD);
        chk("refuse", 8'h08, ov);
        bus(1'h1, `EETC_OFF_CTRL, 32'h0000_0010);
        opx(EETC_OP_DBG_WR);
        chk("grant", 8'h10, ov);
        opx(EETC_OP_PAGE_ADD);
        chk("opt clear", 8'h04, ov);
        $display("debug access test done");
        bus(1'h1, `EETC_OFF_CTRL, 32'h0000_0005);
        bus(1'h1, `EETC_OFF_STATUS, 32'h0000_0004);
        flag_pop_instruction_tf <= 1'h1;
        opx(EETC_OP_ENTER);
        bus(1'h0, `EETC_OFF_STATUS);
        chk("entry class", 2'h1, rd[1:0]);
        opx(EETC_OP_FLAG_POP_INSTRUCTION);
        chk("flag_pop_instruction tf", 1'h0, ov[1]);
        opx(EETC_OP_EXIT);
        chk("exit tf pend", 2'h3, ov[1:0]);
        opx(EETC_OP_NONE, 1'h0, 1'h1);
        chk("step and mtf", 2'h3, ov[7:6]);
        bus(1'h0, `EETC_OFF_STATUS);
        chk("unmask", 2'h0, rd[7:6]);
        $display("opt-out step test done");
        bus(1'h1, `EETC_OFF_STATUS, 32'h0000_0010);
        bus(1'h1, `EETC_OFF_CTRL, 32'h0000_000D);
        repeat (16) begin
            rnd = xs(rnd);
            tcs_opt_in <= rnd[0];
            ssa_vif <= rnd[2];
            flag_pop_instruction_tf <= rnd[4];
            bus(1'h1, `EETC_OFF_STATUS, {27'h000_0000, 2'h2, rnd[3], 2'h0});
            bus(1'h1, `EETC_OFF_PKR_LIVE, rnd);
            opx(EETC_OP_ENTER);
            opx(EETC_OP_FLAG_POP_INSTRUCTION);
            opx(rnd[5] ? EETC_OP_AEX_SMI : EETC_OP_AEX);
            ex = exp_aex(rnd);
            chk("aex tf", ex[0], ov[1]);
            bus(1'h0, `EETC_OFF_SSA);
            chk("saved image", 3'h2, rd[2:0]);
            bus(1'h0, `EETC_OFF_PKR_SAVE);
            chk("key save", rnd, rd);
            bus(1'h0, `EETC_OFF_PKR_LIVE);
            chk("key clear", 32'h0000_0000, rd);
            other_vmexit <= rnd[1];
            opx(EETC_OP_NONE, 1'h0, 1'h1);
            other_vmexit <= 1'h0;
            chk("mtf exit", ex[1], ov[6]);
            opx(EETC_OP_RESUME);
            bus(1'h0, `EETC_OFF_PKR_LIVE);
            chk("key restore", rnd, rd);
            bus(1'h0, `EETC_OFF_STATUS);
            chk("vif and class", {2'h1, rnd[0], 1'h1}, {rd[5:4], rd[1:0]});
            opx(EETC_OP_EXIT);
            opx(EETC_OP_NONE, 1'h0, 1'h1);
            chk("exit step", !rnd[0] && rnd[3], ov[7]);
        end
        $display("asynchronous exit test done");
        bus(1'h1, `EETC_OFF_CTRL, 32'h0000_0002);
        bus(1'h1, `EETC_OFF_STATUS, 32'h0000_0020);
        opx(EETC_OP_STI);
        chk("sti fault", 1'h1, ov[5]);
        bus(1'h0, `EETC_OFF_STATUS);
        chk("sti no change", 3'h4, rd[5:3]);
        io_privilege_level <= 2'h3;
        opx(EETC_OP_STI);
        bus(1'h0, `EETC_OFF_STATUS);
        chk("sti set", 4'h5, {ov[5], rd[5:3]});
        bus(1'h0, 12'h0FC);
        chk("unmapped", 32'h0000_0000, rd);
        $display("interrupt flag test done");
        bus(1'h1, `EETC_OFF_CTRL, 32'h0000_0005);
        bus(1'h1, `EETC_OFF_STATUS, 32'h0000_0004);
        opx(EETC_OP_PRIVILEGED_ENCLAVE_INSTRUCTION);
        chk("privileged_enclave_instruction pend", 2'h3, ov[1:0]);
        opx(EETC_OP_NONE, 1'h0, 1'h1);
        chk("privileged_enclave_instruction step mtf", 2'h3, ov[7:6]);
        op_fault <= 1'h1;
        opx(EETC_OP_PRIVILEGED_ENCLAVE_INSTRUCTION);
        op_fault <= 1'h0;
        opx(EETC_OP_NONE, 1'h0, 1'h1);
        chk("privileged_enclave_instruction fault", 2'h2, ov[7:6]);
        tcs_opt_in <= 1'h0;
        opx(EETC_OP_ENTER);
        opx(EETC_OP_REPORT);
        opx(EETC_OP_NONE, 1'h0, 1'h1);
        chk("masked report", 2'h0, ov[7:6]);
        opx(EETC_OP_EXIT);
        opx(EETC_OP_NONE, 1'h0, 1'h1);
        tcs_opt_in <= 1'h1;
        opx(EETC_OP_ENTER);
        opx(EETC_OP_KEYREQ);
        opx(EETC_OP_NONE, 1'h0, 1'h1);
        chk("unmasked key", 2'h3, ov[7:6]);
        op_fault <= 1'h1;
        opx(EETC_OP_REPORT);
        op_fault <= 1'h0;
        opx(EETC_OP_NONE, 1'h0, 1'h1);
        chk("faulted report", 2'h1, ov[7:6]);
        opx(EETC_OP_EXIT);
        opx(EETC_OP_INTERRUPT_RETURN);
        opx(EETC_OP_NONE, 1'h0, 1'h1);
        chk("interrupt_return arm", 2'h1, {ov[7], ov[0]});
        opx(EETC_OP_NONE, 1'h0, 1'h1);
        chk("interrupt_return step", 2'h2, {ov[7], ov[0]});
        $display("step and monitor trap test done");
        finish_test();
    end
endmodule
